/* File: logic/ordp_pkg.sv */
// On-chip RAM decode package: register map, address windows, bus carriers.
// Assumes a 24-bit byte-wide processor memory bus and an 8-bit register port.
//
// Operation
// [R1] General RAM holds 8 K bytes, single port.
// [R2] Accumulator RAM holds 1 K bytes, dual port, shared with the accumulator.
// [R3] Each RAM enabled separately, placed at top of any 64 KB page.
// [R4] All processor accesses to either RAM move one byte.
// [R5] General RAM answers page-select byte with low half E000h to FFFFh.
// [R6] Accumulator RAM answers page-select byte with low half DC00h to DFFFh.
// [R7] Decode compares all 24 address bits; page select gives the top byte.
// [R8] Enabled RAM hit blocks any overlapping external memory chip select.
// [R9] Control bit 7 enables general RAM; resets to 0.
// [R10] Control bit 6 enables accumulator RAM; resets to 0; bits 5..0 read-only.
// [R11] Page select is read/write, eight bits, resets to zero.
// [R12] RAM priority only touches chip selects of memory type.
// [R13] Memory chip select activates when address bits 23..16 lie within bounds.
// [R14] RAMs ignore I/O cycles; reserved control bits read zero, ignore writes.

package ordp_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFS_RAM_CTRL = 8'hB4;
  localparam logic [7:0] OFS_RAM_PAGE = 8'hB5;
  localparam logic [7:0] RST_RAM_CTRL = 8'h00;
  localparam logic [7:0] RST_RAM_PAGE = 8'h00;
  localparam int BIT_GEN_EN = 7;
  localparam int BIT_MAC_EN = 6;
  localparam logic [7:0] CTRL_RW_MASK = 8'hC0;

  // ----------------------------------------
  // Address windows and sizes
  // ----------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam int GEN_DEPTH = 8192;
  localparam int GEN_AW = 13;
  localparam int MAC_DEPTH = 1024;
  localparam int MAC_AW = 10;
  localparam logic [15:0] GEN_LO = 16'hE000;
  localparam logic [15:0] GEN_HI = 16'hFFFF;
  localparam logic [15:0] MAC_LO = 16'hDC00;
  localparam logic [15:0] MAC_HI = 16'hDFFF;
  localparam int NUM_CS = 4;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic mem;
    logic io;
    logic rd;
    logic wr;
    logic [DATA_W-1:0] wdata;
  } ordp_bus_type;

  typedef struct packed {
    logic [7:0] lower;
    logic [7:0] upper;
    logic io;
    logic en;
  } ordp_cs_type;

endpackage

/* File: logic/ordp_ram_decode.sv */
// On-chip RAM decode: both RAM arrays, their enables, page select and
// chip-select suppression for the processor memory bus.
// Assumes the bus and register port are synchronous to sys_clk and that the
// chip-select bound registers live outside and arrive as configuration.
`timescale 1ns/10ps

module ordp_ram_decode
  import ordp_pkg::*;
(
  input wire logic sys_clk, // System clock, 20 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [7:0] reg_rdata, // Register read data, cycle after strobe
  input wire ordp_bus_type cpu_bus, // Processor bus cycle
  output logic [7:0] cpu_rdata, // RAM read data, cycle after read
  output logic cpu_rvalid, // RAM read data valid
  output logic gen_hit, // Cycle hits general RAM
  output logic mac_hit, // Cycle hits accumulator RAM
  input wire ordp_cs_type [NUM_CS-1:0] cs_cfg, // Chip-select configuration
  output logic [NUM_CS-1:0] cs_mem_n, // Memory chip selects, active low
  input wire logic [MAC_AW-1:0] mac_addr, // Accumulator port address
  input wire logic mac_wr, // Accumulator port write
  input wire logic [7:0] mac_wdata, // Accumulator port write data
  output logic [7:0] mac_rdata // Accumulator port read data
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Full 24-bit window test: top byte from page select, low half in range
  function automatic logic in_window(input logic [ADDR_W-1:0] a, input logic [7:0] page,
                                     input logic [15:0] lo, input logic [15:0] hi);
    in_window = (a[23:16] == page) && (a[15:0] >= lo) && (a[15:0] <= hi);
  endfunction

  // Chip-select bound test on the top address byte
  function automatic logic in_bounds(input logic [ADDR_W-1:0] a, input ordp_cs_type c);
    in_bounds = (a[23:16] >= c.lower) && (a[23:16] <= c.upper);
  endfunction

  // ----------------------------------------
  // Registers and storage
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] page_q;
  logic [7:0] gen_mem [GEN_DEPTH];
  logic [7:0] mac_mem [MAC_DEPTH];
  logic gen_en;
  logic mac_en;
  logic ram_hit;

  assign gen_en = ctrl_q[BIT_GEN_EN];
  assign mac_en = ctrl_q[BIT_MAC_EN];

  // Control register; only the two enable bits are storage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q <= RST_RAM_CTRL; // [R9] [R10]
    end else if (reg_wr && reg_addr == OFS_RAM_CTRL) begin
      ctrl_q <= reg_wdata & CTRL_RW_MASK; // [R9] [R10] [R14]
    end
  end

  // Page select, fully read/write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      page_q <= RST_RAM_PAGE; // [R11]
    end else if (reg_wr && reg_addr == OFS_RAM_PAGE) begin
      page_q <= reg_wdata; // [R11]
    end
  end

  // Register read port; unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_addr == OFS_RAM_CTRL) begin
      reg_rdata <= ctrl_q & CTRL_RW_MASK; // [R10] [R14]
    end else if (reg_rd && reg_addr == OFS_RAM_PAGE) begin
      reg_rdata <= page_q; // [R11]
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Memory cycles only, so an I/O cycle with a forced top byte never lands here
  assign gen_hit = cpu_bus.mem && !cpu_bus.io && gen_en &&
                   in_window(cpu_bus.addr, page_q, GEN_LO, GEN_HI); // [R3] [R5] [R7] [R14]
  assign mac_hit = cpu_bus.mem && !cpu_bus.io && mac_en &&
                   in_window(cpu_bus.addr, page_q, MAC_LO, MAC_HI); // [R3] [R6] [R7] [R14]
  assign ram_hit = gen_hit || mac_hit;

  // Memory chip selects: bounds first, then RAM priority; I/O types stay idle here
  always_comb begin
    for (int i = 0; i < NUM_CS; i++) begin
      cs_mem_n[i] = !(cs_cfg[i].en && !cs_cfg[i].io && cpu_bus.mem && !cpu_bus.io &&
                      in_bounds(cpu_bus.addr, cs_cfg[i]) && !ram_hit); // [R8] [R12] [R13]
    end
  end

  // ----------------------------------------
  // General RAM, single port
  // ----------------------------------------
  // Byte-wide write; one access per bus cycle
  always_ff @(posedge sys_clk) begin
    if (gen_hit && cpu_bus.wr) begin
      gen_mem[cpu_bus.addr[GEN_AW-1:0]] <= cpu_bus.wdata; // [R1] [R4]
    end
  end

  // ----------------------------------------
  // Accumulator RAM, dual port
  // ----------------------------------------
  // Processor write is placed last so it wins a same-address collision
  always_ff @(posedge sys_clk) begin
    if (mac_wr) begin
      mac_mem[mac_addr] <= mac_wdata; // [R2]
    end
    if (mac_hit && cpu_bus.wr) begin
      mac_mem[cpu_bus.addr[MAC_AW-1:0]] <= cpu_bus.wdata; // [R2] [R4]
    end
  end

  // Accumulator side read, registered; old data on a same-cycle write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mac_rdata <= 8'h00;
    end else begin
      mac_rdata <= mac_mem[mac_addr]; // [R2]
    end
  end

  // ----------------------------------------
  // Processor read path
  // ----------------------------------------
  // One registered byte per read, valid for exactly one cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cpu_rdata <= 8'h00;
    end else if (gen_hit && cpu_bus.rd) begin
      cpu_rdata <= gen_mem[cpu_bus.addr[GEN_AW-1:0]]; // [R1] [R4]
    end else if (mac_hit && cpu_bus.rd) begin
      cpu_rdata <= mac_mem[cpu_bus.addr[MAC_AW-1:0]]; // [R2] [R4]
    end
  end

  // Read-valid flag follows any RAM read by one cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cpu_rvalid <= 1'b0;
    end else begin
      cpu_rvalid <= ram_hit && cpu_bus.rd; // [R4]
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence gen_wr_s;
    gen_hit && cpu_bus.wr;
  endsequence

  sequence gen_rd_same_s;
    gen_hit && cpu_bus.rd && cpu_bus.addr == $past(cpu_bus.addr);
  endsequence

  sequence page_wr_s;
    reg_wr && reg_addr == OFS_RAM_PAGE;
  endsequence

  sequence page_rd_s;
    reg_rd && reg_addr == OFS_RAM_PAGE;
  endsequence

  gen_window_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R5]
    gen_hit |-> cpu_bus.mem && ctrl_q[7] && cpu_bus.addr[23:16] == page_q &&
                cpu_bus.addr[15:13] == 3'b111)
    else $error("general RAM hit outside its window");

  mac_window_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
    mac_hit |-> cpu_bus.mem && ctrl_q[6] && cpu_bus.addr[23:16] == page_q &&
                cpu_bus.addr[15:10] == 6'h37)
    else $error("accumulator RAM hit outside its window");

  gen_cover_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
    (cpu_bus.mem && !cpu_bus.io && ctrl_q[7] && cpu_bus.addr[23:16] == page_q &&
     cpu_bus.addr[15:13] == 3'b111) |-> gen_hit)
    else $error("enabled general RAM missed a hit");

  cs_suppress_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
    (gen_hit || mac_hit) |-> cs_mem_n == 4'hF)
    else $error("chip select active during RAM hit");

  io_ignored_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R14]
    cpu_bus.io |-> !gen_hit && !mac_hit && cs_mem_n == 4'hF)
    else $error("RAM or memory select answered an I/O cycle");

  reset_clear_a: assert property (@(posedge sys_clk) // [R9]
    !rst_n |=> ctrl_q == 8'h00 && page_q == 8'h00 && !gen_hit && !mac_hit)
    else $error("RAM registers not cleared by reset");

  ctrl_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
    reg_wr && reg_addr == OFS_RAM_CTRL |=> gen_en == $past(reg_wdata[7]) &&
      mac_en == $past(reg_wdata[6]) && ctrl_q[5:0] == 6'h00)
    else $error("control write not taken correctly");

  ctrl_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R14]
    reg_rd && reg_addr == OFS_RAM_CTRL |=> reg_rdata[5:0] == 6'h00 &&
      reg_rdata[7:6] == {$past(gen_en), $past(mac_en)})
    else $error("control read shows wrong bits");

  page_rw_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
    page_wr_s ##1 page_rd_s |=> reg_rdata == $past(reg_wdata, 2))
    else $error("page select did not read back");

  gen_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
    gen_wr_s ##1 gen_rd_same_s |=> cpu_rvalid && cpu_rdata == $past(cpu_bus.wdata, 2))
    else $error("general RAM lost a written byte");

  generate
    for (genvar g = 0; g < NUM_CS; g++) begin : g_cs_chk
      cs_bounds_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R13]
        !cs_mem_n[g] |-> cs_cfg[g].en && !cs_cfg[g].io &&
          cpu_bus.addr[23:16] >= cs_cfg[g].lower && cpu_bus.addr[23:16] <= cs_cfg[g].upper)
        else $error("memory chip select outside its bounds");
      cs_type_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R12]
        cs_cfg[g].io |-> cs_mem_n[g])
        else $error("I/O-type select drove a memory select");
    end
  endgenerate

  // ----------------------------------------
  // Read path, register hold and select activation
  // ----------------------------------------
  // A RAM read on the bus, either array
  sequence ram_rd_s;
    (gen_hit || mac_hit) && cpu_bus.rd;
  endsequence

  // A write strobe aimed at the control register
  sequence ctrl_wr_s;
    reg_wr && reg_addr == OFS_RAM_CTRL;
  endsequence

  // Every RAM read must raise the valid flag one cycle later
  rvalid_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
    ram_rd_s |=> cpu_rvalid)
    else $error("RAM read gave no valid byte");

  // The valid flag never rises without a RAM read behind it
  rvalid_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
    !((gen_hit || mac_hit) && cpu_bus.rd) |=> !cpu_rvalid)
    else $error("read valid without a RAM read");

  // An enabled accumulator RAM must answer its whole window
  mac_cover_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
    (cpu_bus.mem && !cpu_bus.io && ctrl_q[6] && cpu_bus.addr[23:16] == page_q &&
     cpu_bus.addr[15:10] == 6'h37) |-> mac_hit)
    else $error("enabled accumulator RAM missed a hit");

  // Register read data stands one cycle only, then drops to zero
  rdata_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("register read data outlived its cycle");

  // Enables change only through a control write
  ctrl_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
    !ctrl_wr_s |=> $stable(ctrl_q))
    else $error("control register changed without a write");

  // Page select changes only through its own write
  page_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
    !page_wr_s |=> $stable(page_q))
    else $error("page select changed without a write");

  // A memory select in range with no RAM hit must go active
  generate
    for (genvar h = 0; h < NUM_CS; h++) begin : g_cs_act
      cs_active_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R13]
        (cs_cfg[h].en && !cs_cfg[h].io && cpu_bus.mem && !cpu_bus.io &&
         cpu_bus.addr[23:16] >= cs_cfg[h].lower && cpu_bus.addr[23:16] <= cs_cfg[h].upper &&
         !gen_hit && !mac_hit) |-> !cs_mem_n[h])
        else $error("memory chip select stayed idle in range");
    end
  endgenerate

endmodule // ordp_ram_decode

/* File: sim/ordp_bus_model.sv */
// Processor bus master and chip-select setup facing the RAM decoder.
// Assumes the caller uses drive, then idle, from the clock's edge schedule.
`timescale 1ns/10ps

module ordp_bus_model
  import ordp_pkg::*;
(
  input wire logic sys_clk, // System clock
  output ordp_bus_type cpu_bus, // Processor bus cycle
  output ordp_cs_type [NUM_CS-1:0] cs_cfg // Chip-select setup
);
  // ----------------------------------------
  // Chip selects: 0 wide memory, 1 I/O type, 2 off, 3 one page
  // ----------------------------------------
  assign cs_cfg[0] = {8'h00, 8'hFF, 2'b01};
  assign cs_cfg[1] = {8'h7A, 8'h7A, 2'b11};
  assign cs_cfg[2] = {8'h00, 8'hFF, 2'b00};
  assign cs_cfg[3] = {8'h7A, 8'h7A, 2'b01};

  initial cpu_bus = '0;

  // One cycle, launched just after an edge
  task automatic drive(input logic [23:0] a, input logic m, io, rd, wr,
                       input logic [7:0] d);
    @(posedge sys_clk);
    cpu_bus <= '{addr: a, mem: m, io: io, rd: rd, wr: wr, wdata: d};
  endtask

  // Released bus shows inverted address and data with all controls low, not the stale cycle
  task automatic idle;
    @(posedge sys_clk);
    cpu_bus <= '{addr: ~cpu_bus.addr, mem: 1'b0, io: 1'b0, rd: 1'b0, wr: 1'b0,
                 wdata: ~cpu_bus.wdata};
  endtask
endmodule // ordp_bus_model

/* File: sim/tb_onchip_ram_decode.sv */
// Self-checking bench for the on-chip RAM decoder.
// Assumes the bus model above drives the processor side.
`timescale 1ns/10ps

module tb_onchip_ram_decode;
  import ordp_pkg::*;
  logic sys_clk, rst_n, reg_wr, reg_rd, mac_wr, cpu_rvalid, gen_hit, mac_hit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cpu_rdata, mac_wdata, mac_rdata;
  logic [MAC_AW-1:0] mac_addr;
  logic [NUM_CS-1:0] cs_mem_n;
  ordp_bus_type cpu_bus;
  ordp_cs_type [NUM_CS-1:0] cs_cfg;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Rows: address, io, gen hit, mac hit, 0, chip selects; page 7A
  localparam logic [31:0] ROWS [8] = '{32'h7AE000_4F, 32'h7AFFFF_4F, 32'h7ADFFF_2F,
    32'h7ADC00_2F, 32'h7ADBFF_06, 32'h7BE000_0E, 32'h79E000_0E, 32'h7AE000_8F};

  ordp_bus_model u_bus (.sys_clk(sys_clk), .cpu_bus(cpu_bus), .cs_cfg(cs_cfg));
  ordp_ram_decode u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_bus(cpu_bus), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .gen_hit(gen_hit), .mac_hit(mac_hit), .cs_cfg(cs_cfg), .cs_mem_n(cs_mem_n),
    .mac_addr(mac_addr), .mac_wr(mac_wr), .mac_wdata(mac_wdata), .mac_rdata(mac_rdata));

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Whole run needs under a hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  task automatic bus_rw(input logic [23:0] a, input logic wr, input logic [7:0] d);
    u_bus.drive(a, 1'b1, 1'b0, ~wr, wr, d);
    u_bus.idle();
    #1;
  endtask

  task automatic close_out;
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, mac_wr, reg_addr, reg_wdata, mac_wdata, mac_addr} = '0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    reg_read(OFS_RAM_CTRL, RST_RAM_CTRL);
    reg_read(OFS_RAM_PAGE, RST_RAM_PAGE);
    u_bus.drive(24'h00E000, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
    #1 check(gen_hit, 1'b0);
    check(cs_mem_n, 4'hE);
    u_bus.idle();
    reg_write(OFS_RAM_PAGE, 8'h7A);
    reg_write(OFS_RAM_CTRL, 8'hFF);
    reg_write(8'hB6, 8'h55);
    reg_read(OFS_RAM_CTRL, 8'hC0);
    reg_read(OFS_RAM_PAGE, 8'h7A);
    reg_read(8'hB6, 8'h00);
    // Window edges, page mismatch and I/O cycle
    foreach (ROWS[i]) begin
      u_bus.drive(ROWS[i][31:8], ~ROWS[i][7], ROWS[i][7], 1'b1, 1'b0, 8'h00);
      #1 check(gen_hit, ROWS[i][6]);
      check(mac_hit, ROWS[i][5]);
      check(cs_mem_n, ROWS[i][3:0]);
      u_bus.idle();
    end
    // Data through both arrays, both ports
    bus_rw(24'h7AE010, 1'b1, 8'h55);
    bus_rw(24'h7AFFFF, 1'b1, 8'hAA);
    bus_rw(24'h7AE010, 1'b0, 8'h00);
    check(cpu_rdata, 8'h55);
    check(cpu_rvalid, 1'b1);
    bus_rw(24'h7AFFFF, 1'b0, 8'h00);
    check(cpu_rdata, 8'hAA);
    bus_rw(24'h7ADC05, 1'b1, 8'hA3);
    @(posedge sys_clk);
    mac_addr <= 10'h005;
    mac_wr <= 1'b1;
    mac_wdata <= 8'h3C;
    @(posedge sys_clk);
    mac_wr <= 1'b0;
    #1 check(mac_rdata, 8'hA3);
    bus_rw(24'h7ADC05, 1'b0, 8'h00);
    check(cpu_rdata, 8'h3C);
    // Relocate, accumulator RAM off
    reg_write(OFS_RAM_PAGE, 8'h12);
    reg_write(OFS_RAM_CTRL, 8'h80);
    u_bus.drive(24'h12E000, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
    #1 check(gen_hit, 1'b1);
    u_bus.idle();
    u_bus.drive(24'h12DC00, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
    #1 check(mac_hit, 1'b0);
    check(cs_mem_n, 4'hE);
    u_bus.idle();
    #1 check(cpu_rvalid, 1'b0);
    // Write then read the same byte with no gap
    u_bus.drive(24'h12E123, 1'b1, 1'b0, 1'b0, 1'b1, 8'h96);
    u_bus.drive(24'h12E123, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
    u_bus.idle();
    #1 check(cpu_rdata, 8'h96);
    // Register write and read strobes back to back
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= OFS_RAM_PAGE;
    reg_wdata <= 8'h5A;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, 8'h5A);
    @(posedge sys_clk);
    #1 check(reg_rdata, 8'h00);
    // Reset in mid-run clears both registers and the hits
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    reg_read(OFS_RAM_CTRL, RST_RAM_CTRL);
    reg_read(OFS_RAM_PAGE, RST_RAM_PAGE);
    u_bus.drive(24'h00E000, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
    #1 check(gen_hit, 1'b0);
    u_bus.idle();
    close_out();
  end
endmodule // tb_onchip_ram_decode
